// [rtl/gcp_pkg.sv]
// Shared constants and types of the gain control port.
package gcp_pkg;
   // ****************************************
   // Serial frame layout
   // ****************************************
   localparam logic [4:0] GCP_CMD_LAST   = 5'h07;
   localparam logic [4:0] GCP_FRAME_LAST = 5'h0f;
   localparam logic [4:0] GCP_DATA_FIRST = 5'h08;
   localparam int         GCP_DIR_BIT    = 7;
   localparam int         GCP_PWR_BIT    = 6;
   localparam int         GCP_ON_BIT     = 5;
   localparam logic [2:0] GCP_ADDR_FAST  = 3'h4;
   localparam logic [2:0] GCP_ADDR_RESET = 3'h0;
   localparam logic [4:0] GCP_ATT_MAX    = 5'h1f;
   localparam logic [4:0] GCP_ATT_MIN    = 5'h00;
   localparam logic [7:0] GCP_CH_RESET   = 8'h1f;
   localparam logic [7:0] GCP_FAST_RESET = 8'h00;
   localparam logic [9:0] GCP_SYNC_RESET = 10'h01f;
   // ****************************************
   // Register bus map
   // ****************************************
   localparam logic [7:0] GCP_OFF_STATUS = 8'h00;
   localparam logic [7:0] GCP_OFF_CH0    = 8'h04;
   localparam logic [7:0] GCP_OFF_FAST   = 8'h14;
   localparam logic [7:0] GCP_OFF_CTRL   = 8'h18;
   localparam logic [31:0] GCP_CTRL_RESET = 32'h0;
   localparam int         GCP_CTRL_WPROT = 0;
   typedef enum logic [1:0] {
      GCP_PWR_OFF  = 2'b00,
      GCP_PWR_LOW  = 2'b01,
      GCP_PWR_HIGH = 2'b10
   } gcp_pwr_type;
   typedef enum logic [1:0] {
      GCP_FA_HOLD = 2'b00,
      GCP_FA_DOWN = 2'b01,
      GCP_FA_UP   = 2'b10,
      GCP_FA_RSVD = 2'b11
   } gcp_fa_type;
   typedef enum logic [1:0] {
      GCP_IDLE  = 2'b00,
      GCP_SHIFT = 2'b01,
      GCP_FULL  = 2'b10
   } gcp_state_type;
   typedef struct packed {
      gcp_pwr_type pwr;
      logic [4:0]  att;
   } gcp_chan_type;
endpackage

// [rtl/gcp_sync.sv]
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module gcp_sync
   import gcp_pkg::*;
#(
   parameter int             W       = 10,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

// [rtl/gcp_ahb.sv]
// AHB-Lite slave holding the control register and the read mux.
`timescale 1ns/1ps
module gcp_ahb
   import gcp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [31:0] status_word,
   input  wire logic [39:0] chan_view,
   input  wire logic [7:0]  fast_view,
   output logic             wprot
);
   logic        pend_reg, pend_next;
   logic        wr_reg, wr_next;
   logic [7:0]  addr_reg, addr_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] rdata_next;
   logic        ready_next;

   // ****************************************
   // One wait state so read data leave a flop
   // ****************************************
   always_comb begin
      pend_next  = 1'b0;
      wr_next    = wr_reg;
      addr_next  = addr_reg;
      ctrl_next  = ctrl_reg;
      rdata_next = hrdata;
      ready_next = 1'b1;
      if (hsel && htrans[1] && hready) begin
         pend_next  = 1'b1;
         ready_next = 1'b0;
         wr_next    = hwrite;
         addr_next  = haddr[7:0];
      end
      if (pend_reg) begin
         rdata_next = 32'h0;
         if (wr_reg && addr_reg == GCP_OFF_CTRL) begin
            ctrl_next = hwdata;
         end else if (!wr_reg) begin
            case (addr_reg)
               GCP_OFF_STATUS: rdata_next = status_word;
               GCP_OFF_CH0:    rdata_next = {24'h0, chan_view[7:0]};
               8'h08:          rdata_next = {24'h0, chan_view[15:8]};
               8'h0c:          rdata_next = {24'h0, chan_view[23:16]};
               8'h10:          rdata_next = {24'h0, chan_view[31:24]};
               GCP_OFF_FAST:   rdata_next = {24'h0, fast_view};
               GCP_OFF_CTRL:   rdata_next = {31'h0, ctrl_reg[0]};
               default:        rdata_next = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend_reg  <= 1'b0;
         wr_reg    <= 1'b0;
         addr_reg  <= 8'h0;
         ctrl_reg  <= GCP_CTRL_RESET;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         pend_reg  <= pend_next;
         wr_reg    <= wr_next;
         addr_reg  <= addr_next;
         ctrl_reg  <= ctrl_next;
         hrdata    <= rdata_next;
         hreadyout <= ready_next;
         hresp     <= 1'b0;
      end
   end

   assign wprot = ctrl_reg[GCP_CTRL_WPROT];
endmodule

// [rtl/gcp_port.sv]
// Gain control port: parallel pins or serial register frames.
`timescale 1ns/1ps
module gcp_port
   import gcp_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         mode_strap,
   input  wire logic         mode_strap_drv,
   input  wire logic         atten_bit4_in,
   output logic              atten_bit4_out,
   output logic              atten_bit4_oe,
   input  wire logic         atten_bit3,
   input  wire logic         atten_bit2,
   input  wire logic         atten_bit1,
   input  wire logic         atten_bit0,
   input  wire logic [4:0]   atten_drv,
   input  wire logic         channel_a_on,
   input  wire logic         channel_b_on,
   input  wire logic [1:0]   chan_on_drv,
   output gcp_chan_type [3:0] gain_ch,
   output logic              mode_serial,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata
);
   // ****************************************
   // Decoding helpers
   // ****************************************
   function automatic gcp_chan_type to_out(input logic [7:0] r);
      gcp_chan_type o;
      o.att = r[4:0];
      if (!r[GCP_ON_BIT]) o.pwr = GCP_PWR_OFF;
      else if (r[GCP_PWR_BIT]) o.pwr = GCP_PWR_HIGH;
      else o.pwr = GCP_PWR_LOW;
      return o;
   endfunction

   function automatic logic [4:0] step(input logic [4:0] a,
                                       input logic [1:0] c);
      logic [4:0] r;
      r = a;
      if (c == GCP_FA_DOWN && a != GCP_ATT_MIN) r = a - 5'h01;
      if (c == GCP_FA_UP && a != GCP_ATT_MAX) r = a + 5'h01;
      return r;
   endfunction

   // ****************************************
   // Pin resolution and synchronisation
   // ****************************************
   logic [9:0] raw;
   logic [9:0] syn;
   logic [4:0] bus_raw;
   logic       ser;
   logic       sdi_s, cs_s, sck_s;
   logic       en_a_drv, en_a, en_b_drv, en_b;

   // Weak pull-ups and pull-down are modelled by the drive flags.
   always_comb begin
      bus_raw = {atten_bit4_in, atten_bit3, atten_bit2, atten_bit1,
                 atten_bit0} | ~atten_drv;
      raw = {chan_on_drv[1], channel_b_on, chan_on_drv[0], channel_a_on,
             mode_strap & mode_strap_drv, bus_raw};
   end

   gcp_sync #(.W(10), .RST_VAL(GCP_SYNC_RESET)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       (raw),
      .q       (syn)
   );

   assign ser      = syn[5];
   assign sdi_s    = syn[3];
   assign cs_s     = syn[2];
   assign sck_s    = syn[1];
   assign en_a     = syn[6];
   assign en_a_drv = syn[7];
   assign en_b     = syn[8];
   assign en_b_drv = syn[9];

   // ****************************************
   // Serial frame engine and gain registers
   // ****************************************
   gcp_state_type    state_reg, state_next;
   logic [4:0]       cnt_reg, cnt_next;
   logic [15:0]      shin_reg, shin_next;
   logic [7:0]       dout_reg, dout_next;
   logic             sout_next, oe_next;
   logic [2:0]       addr_reg, addr_next;
   logic [7:0]       fast_reg, fast_next;
   logic [3:0][7:0]  ch_reg, ch_next;
   logic             cs_prev_reg, sck_prev_reg;
   logic             cs_fall, cs_rise, sck_rise, sck_fall;
   logic             wprot;
   logic             en_on, en_hi;
   logic [7:0]       cmd_byte;
   logic [7:0]       cmd_now;
   gcp_chan_type [3:0] gain_next;

   assign cs_fall  = cs_prev_reg & ~cs_s;
   assign cs_rise  = ~cs_prev_reg & cs_s;
   assign sck_rise = ~sck_prev_reg & sck_s;
   assign sck_fall = sck_prev_reg & ~sck_s;
   assign cmd_byte = shin_reg[15:8];
   assign cmd_now  = {shin_reg[6:0], sdi_s};

   function automatic logic [7:0] read_reg(input logic [2:0] a,
                                           input logic [3:0][7:0] c,
                                           input logic [7:0] f);
      logic [7:0] r;
      r = 8'h00;
      if (a < GCP_ADDR_FAST) r = c[a[1:0]];
      else if (a == GCP_ADDR_FAST) r = f;
      return r;
   endfunction

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shin_next  = shin_reg;
      dout_next  = dout_reg;
      sout_next  = atten_bit4_out;
      addr_next  = addr_reg;
      fast_next  = fast_reg;
      ch_next    = ch_reg;
      en_on      = 1'b0;
      en_hi      = 1'b0;
      oe_next    = ser & ~cs_s;
      if (!ser) begin
         state_next = GCP_IDLE;
         for (int i = 0; i < 4; i++) begin
            // Undriven enable floats to the low-power state.
            en_on = (i < 2) ? (~en_a_drv | en_a)
                            : (~en_b_drv | en_b);
            en_hi = (i < 2) ? (en_a_drv & en_a) : (en_b_drv & en_b);
            ch_next[i][7:5] = {1'b0, en_hi, en_on};
            if (en_on) begin
               ch_next[i][4:0] = syn[4:0];
            end
            // A disabled channel leaves its attenuation untouched.
         end
      end else if (cs_fall) begin
         state_next = GCP_SHIFT;
         cnt_next   = 5'h00;
         sout_next  = 1'b0;
      end else if (cs_rise) begin
         state_next = GCP_IDLE;
         if (state_reg == GCP_FULL) begin
            addr_next = cmd_byte[2:0];
            if (!cmd_byte[GCP_DIR_BIT] && !wprot) begin
               if (cmd_byte[2:0] < GCP_ADDR_FAST) begin
                  ch_next[cmd_byte[1:0]] = {1'b0, shin_reg[6:0]};
               end else if (cmd_byte[2:0] == GCP_ADDR_FAST) begin
                  fast_next = shin_reg[7:0];
                  for (int i = 0; i < 4; i++) begin
                     ch_next[i][4:0] = step(ch_reg[i][4:0],
                                            shin_reg[2*i +: 2]);
                  end
               end
            end
         end
      end else if (state_reg == GCP_SHIFT) begin
         if (sck_rise) begin
            shin_next = {shin_reg[14:0], sdi_s};
            cnt_next  = cnt_reg + 5'h01;
            if (cnt_reg == GCP_CMD_LAST) begin
               dout_next = read_reg(cmd_now[2:0], ch_reg, fast_reg);
            end
            if (cnt_reg == GCP_FRAME_LAST) begin
               state_next = GCP_FULL;
            end
         end else if (sck_fall && cnt_reg >= GCP_DATA_FIRST) begin
            sout_next = dout_reg[7];
            dout_next = {dout_reg[6:0], 1'b0};
         end
      end
      // Extra clocks after the sixteenth are ignored in the full state.
      for (int i = 0; i < 4; i++) begin
         gain_next[i] = to_out(ch_next[i]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg      <= GCP_IDLE;
         cnt_reg        <= 5'h00;
         shin_reg       <= 16'h0000;
         dout_reg       <= 8'h00;
         atten_bit4_out <= 1'b0;
         atten_bit4_oe  <= 1'b0;
         addr_reg       <= GCP_ADDR_RESET;
         fast_reg       <= GCP_FAST_RESET;
         ch_reg         <= {4{GCP_CH_RESET}};
         gain_ch        <= {4{to_out(GCP_CH_RESET)}};
         // Both match the synchroniser's reset output, so no false edge.
         cs_prev_reg    <= 1'b1;
         sck_prev_reg   <= 1'b1;
         mode_serial    <= 1'b0;
      end else begin
         state_reg      <= state_next;
         cnt_reg        <= cnt_next;
         shin_reg       <= shin_next;
         dout_reg       <= dout_next;
         atten_bit4_out <= sout_next;
         atten_bit4_oe  <= oe_next;
         addr_reg       <= addr_next;
         fast_reg       <= fast_next;
         ch_reg         <= ch_next;
         gain_ch        <= gain_next;
         cs_prev_reg    <= cs_s;
         sck_prev_reg   <= sck_s;
         mode_serial    <= ser;
      end
   end

   // ****************************************
   // Register bus
   // ****************************************
   gcp_ahb u_ahb (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hsize       (hsize),
      .hwdata      (hwdata),
      .hready      (hready),
      .hreadyout   (hreadyout),
      .hresp       (hresp),
      .hrdata      (hrdata),
      .status_word ({21'h0, addr_reg, cnt_reg, state_reg, ser}),
      .chan_view   ({8'h00, ch_reg}),
      .fast_view   (fast_reg),
      .wprot       (wprot)
   );

   // ****************************************
   // Assertions
   // ****************************************
   property p_mode;
      @(posedge clk) disable iff (sys_rst) ser |=> mode_serial;
   endproperty
   a_mode: assert property (p_mode) else $error("mode not followed");

   property p_oe;
      @(posedge clk) disable iff (sys_rst) cs_s |=> !atten_bit4_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("output driven idle");

   property p_start;
      @(posedge clk) disable iff (sys_rst)
         (ser && cs_fall) |=> (cnt_reg == 5'h00 && state_reg == GCP_SHIFT);
   endproperty
   a_start: assert property (p_start) else $error("frame start");

   property p_early;
      @(posedge clk) disable iff (sys_rst)
         (ser && cs_rise && state_reg != GCP_FULL) |=>
            ($stable(ch_reg) && $stable(addr_reg) && $stable(fast_reg));
   endproperty
   a_early: assert property (p_early) else $error("early write");

   property p_addr;
      @(posedge clk) disable iff (sys_rst)
         (ser && cs_rise && state_reg == GCP_FULL) |=>
            addr_reg == $past(shin_reg[10:8]);
   endproperty
   a_addr: assert property (p_addr) else $error("address latch");

   property p_write;
      @(posedge clk) disable iff (sys_rst)
         (ser && cs_rise && state_reg == GCP_FULL && !wprot &&
          shin_reg[15:10] == 6'h00) |=>
            ch_reg[$past(shin_reg[9:8])] == {1'b0, $past(shin_reg[6:0])};
   endproperty
   a_write: assert property (p_write) else $error("no write");

   property p_par;
      @(posedge clk) disable iff (sys_rst)
         (!ser && (!en_a_drv || en_a)) |=> ch_reg[0][4:0] == $past(syn[4:0]);
   endproperty
   a_par: assert property (p_par) else $error("bus not applied");

   property p_hold;
      @(posedge clk) disable iff (sys_rst)
         (!ser && en_a_drv && !en_a) |=> $stable(ch_reg[0][4:0]) &&
            gain_ch[0].pwr == GCP_PWR_OFF;
   endproperty
   a_hold: assert property (p_hold) else $error("hold lost");

   property p_shift;
      @(posedge clk) disable iff (sys_rst)
         (ser && !cs_rise && !cs_fall && state_reg == GCP_SHIFT && sck_fall
          && cnt_reg >= GCP_DATA_FIRST) |=>
            atten_bit4_out == $past(dout_reg[7]);
   endproperty
   a_shift: assert property (p_shift) else $error("bad shift out");

   c_write: cover property (@(posedge clk) disable iff (sys_rst)
      ser && cs_rise && state_reg == GCP_FULL && !cmd_byte[GCP_DIR_BIT]);
   c_read: cover property (@(posedge clk) disable iff (sys_rst)
      ser && cs_rise && state_reg == GCP_FULL && cmd_byte[GCP_DIR_BIT]);
   c_par: cover property (@(posedge clk) disable iff (sys_rst)
      !ser && en_a_drv && !en_a);
endmodule

// [test/gcp_host.sv]
// Behavioural serial host that runs register frames on the shared pins.
`timescale 1ns/1ps
module gcp_host (
   output logic      link_clk,
   output logic      serial_in,
   output logic      select_low,
   input  wire logic serial_out
);
   // ****************************************
   // Frame engine
   // ****************************************
   initial begin
      link_clk   = 1'b0;
      serial_in  = 1'b0;
      select_low = 1'b1;
   end
   // The clock idles low between frames and runs at 64 ns within them.
   task automatic frame(input logic [7:0] cmd, input logic [7:0] data,
                        input int nbits, output logic [7:0] rd);
      logic [15:0] word;
      word = {cmd, data};
      rd = 8'h00;
      select_low = 1'b0;
      #40;
      for (int i = 0; i < nbits; i++) begin
         serial_in = word[15-i];
         #32 link_clk = 1'b1;
         #32;
         // Sampled late in the high phase, well after the device's fall.
         if (i >= 8) begin
            rd = {rd[6:0], serial_out};
         end
         link_clk = 1'b0;
      end
      #40 select_low = 1'b1;
      // A released data line must not keep looking like valid data.
      serial_in = ~serial_in;
      #100;
   endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the gain control port.
`timescale 1ns/1ps
module testbench
   import gcp_pkg::*;
;
   logic               clk;
   logic               sys_rst;
   logic               mode_strap;
   logic               mode_strap_drv;
   logic               ser_pins;
   logic [4:0]         par_atten;
   logic [4:0]         atten_drv;
   logic               channel_a_on;
   logic               channel_b_on;
   logic [1:0]         chan_on_drv;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hreadyout;
   logic               hresp;
   logic [31:0]        hrdata;
   logic               atten_bit4_out;
   logic               atten_bit4_oe;
   logic               pin4;
   logic               link_clk;
   logic               serial_in;
   logic               select_low;
   gcp_chan_type [3:0] gain_ch;
   logic               mode_serial;
   logic [31:0]        rd;
   logic [7:0]         sr;
   int                 num_errors;
   int                 checks;
   // ****************************************
   // Pins and instances
   // ****************************************
   // The serial output line is biased high whenever nobody drives it.
   assign pin4 = atten_bit4_oe ? atten_bit4_out
                               : (ser_pins ? 1'b1 : par_atten[4]);
   initial clk = 1'b0;
   always #4 clk = ~clk;
   gcp_port gcp_port_i (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .mode_strap     (mode_strap),
      .mode_strap_drv (mode_strap_drv),
      .atten_bit4_in  (pin4),
      .atten_bit4_out (atten_bit4_out),
      .atten_bit4_oe  (atten_bit4_oe),
      .atten_bit3     (ser_pins ? serial_in : par_atten[3]),
      .atten_bit2     (ser_pins ? select_low : par_atten[2]),
      .atten_bit1     (ser_pins ? link_clk : par_atten[1]),
      .atten_bit0     (par_atten[0]),
      .atten_drv      (atten_drv),
      .channel_a_on   (channel_a_on),
      .channel_b_on   (channel_b_on),
      .chan_on_drv    (chan_on_drv),
      .gain_ch        (gain_ch),
      .mode_serial    (mode_serial),
      .hsel           (hsel),
      .haddr          (haddr),
      .htrans         (htrans),
      .hwrite         (hwrite),
      .hsize          (hsize),
      .hwdata         (hwdata),
      .hready         (hreadyout),
      .hreadyout      (hreadyout),
      .hresp          (hresp),
      .hrdata         (hrdata)
   );
   gcp_host gcp_host_i (
      .link_clk   (link_clk),
      .serial_in  (serial_in),
      .select_low (select_low),
      .serial_out (pin4)
   );
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] chv(input gcp_pwr_type p,
                                      input logic [4:0] a);
      return {25'h0, p, a};
   endfunction
   task automatic chk_ch(input int i, input logic [31:0] exp);
      cmp("gain channel", exp, {25'h0, gain_ch[i]});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Single word transfer; waits on hready with no assumed latency.
   task automatic ahb(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= addr;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      cmp("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic end_of_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      {sys_rst, mode_strap, mode_strap_drv, ser_pins} = 4'b1100;
      {par_atten, atten_drv} = 10'h0;
      {channel_a_on, channel_b_on, chan_on_drv} = 4'h0;
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      num_errors = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      ahb(1'b0, 32'(GCP_OFF_STATUS), 32'h0, rd);
      cmp("status", 32'h0, rd);
      settle(6);
      for (int i = 0; i < 4; i++) chk_ch(i, chv(GCP_PWR_LOW, 5'h1f));
      atten_drv <= 5'h1f;
      settle(6);
      for (int i = 0; i < 4; i++) chk_ch(i, chv(GCP_PWR_LOW, 5'h00));
      atten_drv <= 5'h00;
      settle(6);
      for (int i = 0; i < 4; i++) chk_ch(i, chv(GCP_PWR_LOW, 5'h1f));
      // Chosen to match the idle serial pins, so the mode change is clean.
      par_atten <= 5'h14;
      atten_drv <= 5'h1f;
      chan_on_drv <= 2'b11;
      channel_b_on <= 1'b1;
      settle(6);
      chk_ch(1, chv(GCP_PWR_OFF, 5'h1f));
      chk_ch(3, chv(GCP_PWR_HIGH, 5'h14));
      channel_a_on <= 1'b1;
      settle(6);
      chk_ch(0, chv(GCP_PWR_HIGH, 5'h14));
      mode_strap_drv <= 1'b1;
      settle(6);
      cmp("mode", 32'h1, {31'h0, mode_serial});
      ser_pins <= 1'b1;
      channel_a_on <= 1'b0;
      settle(6);
      chk_ch(0, chv(GCP_PWR_HIGH, 5'h14));
      gcp_host_i.frame(8'h80, 8'h00, 16, sr);
      cmp("read ch0", 32'h74, {24'h0, sr});
      cmp("out enable", 32'h0, {31'h0, atten_bit4_oe});
      gcp_host_i.frame(8'h01, 8'hb5, 16, sr);
      settle(4);
      chk_ch(1, chv(GCP_PWR_LOW, 5'h15));
      gcp_host_i.frame(8'h81, 8'h00, 16, sr);
      cmp("read ch1", 32'h35, {24'h0, sr});
      gcp_host_i.frame(8'h02, 8'h00, 10, sr);
      settle(4);
      chk_ch(2, chv(GCP_PWR_HIGH, 5'h14));
      ahb(1'b0, 32'(GCP_OFF_STATUS), 32'h0, rd);
      cmp("latched addr", 32'h1, {29'h0, rd[10:8]});
      gcp_host_i.frame(8'h04, 8'he4, 16, sr);
      settle(4);
      chk_ch(0, chv(GCP_PWR_HIGH, 5'h14));
      chk_ch(1, chv(GCP_PWR_LOW, 5'h14));
      chk_ch(2, chv(GCP_PWR_HIGH, 5'h15));
      ahb(1'b0, 32'(GCP_OFF_FAST), 32'h0, rd);
      cmp("fast reg", 32'he4, rd);
      ahb(1'b0, 32'h8, 32'h0, rd);
      cmp("ch1 reg", 32'h34, rd);
      gcp_host_i.frame(8'h82, 8'h00, 16, sr);
      cmp("read ch2", 32'h75, {24'h0, sr});
      ahb(1'b1, 32'(GCP_OFF_CTRL), 32'h1, rd);
      ahb(1'b0, 32'(GCP_OFF_CTRL), 32'h0, rd);
      cmp("ctrl", 32'h1, rd);
      gcp_host_i.frame(8'h00, 8'h00, 16, sr);
      settle(4);
      chk_ch(0, chv(GCP_PWR_HIGH, 5'h14));
      ahb(1'b1, 32'(GCP_OFF_CTRL), 32'h0, rd);
      gcp_host_i.frame(8'h00, 8'h63, 16, sr);
      gcp_host_i.frame(8'h03, 8'h20, 16, sr);
      settle(4);
      chk_ch(0, chv(GCP_PWR_HIGH, 5'h03));
      chk_ch(3, chv(GCP_PWR_LOW, 5'h00));
      ahb(1'b0, 32'h40, 32'h0, rd);
      cmp("unmapped", 32'h0, rd);
      ahb(1'b1, 32'(GCP_OFF_CH0), 32'h0, rd);
      ahb(1'b0, 32'(GCP_OFF_CH0), 32'h0, rd);
      cmp("ch0 reg", 32'h63, rd);
      end_of_test();
   end
   // The sequence needs about 11 us; some eighteen times that means a hang.
   initial begin
      #200000;
      num_errors++;
      $display("[ERR] watchdog expected done seen hang");
      end_of_test();
   end
endmodule
